// File: rtl/sts_start_clock_top.sv
// Purpose: machine clock generator and delayed start pulse sequencer
// Assumes: sys_clk 100 MHz, all pins asynchronous except width_set, gap_set and gated_clock_enable
// Notes:   start delay and widths counted on a microsecond tick
`timescale 1ns/1ns
module sts_start_clock_top
  import sts_pkg::*;
#(
  parameter int DELAY_US   = DELAY_US_NOM,
  parameter int PULSE_US   = PULSE_US_NOM,
  parameter int RESET_US   = RESET_US_NOM,
  parameter int TICK_CYC   = TICK_CYCLES,
  parameter int FILT_CYC   = GLITCH_CYC
) (
  // clock and reset
  input  wire logic                   sys_clk,
  input  wire logic                   reset,
  // start requests
  input  wire logic                   start_trigger,
  input  wire logic                   manual_start_button,
  // clock control pins
  input  wire logic                   clock_start,
  input  wire logic                   single_pulse_clock,
  input  wire logic                   single_pulse_fitted,
  // clock settings, in sys_clk cycles
  input  wire logic [CNT_W-1:0]       width_set,
  input  wire logic [CNT_W-1:0]       gap_set,
  // gate from machine logic
  input  wire logic                   gated_clock_enable,
  // clock outputs
  output logic      [NUM_CLK_OUT-1:0] clock_out,
  output logic                        gated_clock_out,
  // reset and start outputs
  output logic                        direct_reset_pulse_one,
  output logic                        direct_reset_pulse_two,
  output logic                        direct_reset_pulse_three,
  output logic                        delayed_start_pulse
);

  localparam int RESET_CYC = RESET_US * TICK_CYC;
  localparam int DELAY_CYC = DELAY_US * TICK_CYC;
  localparam int PULSE_CYC = PULSE_US * TICK_CYC;

  // ----------------------------------------------------------------
  // pin filtering
  // ----------------------------------------------------------------
  logic [NUM_PINS-1:0] pins;
  logic [NUM_PINS-1:0] pin_level;
  logic [NUM_PINS-1:0] pin_rise;

  assign pins = {single_pulse_fitted, single_pulse_clock, clock_start,
                 manual_start_button, start_trigger};

  genvar gi;
  generate
    for (gi = 0; gi < NUM_PINS; gi++) begin : g_pin
      sts_pin_if lnk ();
      sts_pin_filter #(
        .FILT_CYC (FILT_CYC)
      ) u_filt (
        .sys_clk (sys_clk),
        .reset   (reset),
        .pin_raw (pins[gi]),
        .link    (lnk.src)
      );
      assign pin_level[gi] = lnk.level;
      assign pin_rise[gi]  = lnk.rise;
    end
  endgenerate

  // ----------------------------------------------------------------
  // start sequencer
  // ----------------------------------------------------------------
  sts_seq_t                seq_reg;
  sts_seq_t                seq_next;
  logic     [CNT_W-1:0]    tick_cnt_reg;
  logic     [US_W-1:0]     us_cnt_reg;
  logic     [NUM_RESET-1:0] rst_reg;
  logic                    dsp_reg;
  logic                    tick;
  logic                    accept;
  logic                    delay_done;
  logic                    pulse_done;

  assign tick       = (tick_cnt_reg == CNT_W'(TICK_CYC - 1));
  assign accept     = (seq_reg == SEQ_IDLE) && (pin_rise[PIN_START] || pin_rise[PIN_BUTTON]);
  assign delay_done = tick && (us_cnt_reg == US_W'(DELAY_US - 1));
  assign pulse_done = tick && (us_cnt_reg == US_W'(PULSE_US - 1));

  always_comb begin
    seq_next = seq_reg;
    case (seq_reg)
      SEQ_IDLE: begin
        if (accept) begin
          seq_next = SEQ_WAIT;
        end
      end
      SEQ_WAIT: begin
        if (delay_done) begin
          seq_next = SEQ_FIRE;
        end
      end
      SEQ_FIRE: begin
        if (pulse_done) begin
          seq_next = SEQ_IDLE;
        end
      end
      default: begin
        seq_next = SEQ_IDLE;
      end
    endcase
  end

  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      seq_reg <= SEQ_IDLE;
    end else begin
      seq_reg <= seq_next;
    end
  end

  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      tick_cnt_reg <= '0;
    end else if (accept || tick) begin
      tick_cnt_reg <= '0;
    end else begin
      tick_cnt_reg <= tick_cnt_reg + 1'b1;
    end
  end

  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      us_cnt_reg <= '0;
    end else if (accept || ((seq_reg == SEQ_WAIT) && delay_done)) begin
      us_cnt_reg <= '0;
    end else if (tick) begin
      us_cnt_reg <= us_cnt_reg + 1'b1;
    end
  end

  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      rst_reg <= '0;
    end else if (accept) begin
      rst_reg <= '1;
    end else if ((seq_reg == SEQ_WAIT) && tick && (us_cnt_reg == US_W'(RESET_US - 1))) begin
      rst_reg <= '0;
    end
  end

  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      dsp_reg <= 1'b0;
    end else if ((seq_reg == SEQ_WAIT) && delay_done) begin
      dsp_reg <= 1'b1;
    end else if ((seq_reg == SEQ_FIRE) && pulse_done) begin
      dsp_reg <= 1'b0;
    end
  end

  assign direct_reset_pulse_one   = rst_reg[0];
  assign direct_reset_pulse_two   = rst_reg[1];
  assign direct_reset_pulse_three = rst_reg[2];
  assign delayed_start_pulse      = dsp_reg;

  // ----------------------------------------------------------------
  // clock generator
  // ----------------------------------------------------------------
  sts_gen_t               gen_reg;
  sts_gen_t               gen_next;
  logic     [CNT_W-1:0]   gen_cnt_reg;
  logic     [CNT_W-1:0]   gen_cnt_next;
  logic     [CNT_W-1:0]   width_eff;
  logic     [CNT_W-1:0]   gap_eff;
  logic     [NUM_CLK_OUT-1:0] clk_out_reg;
  logic                   gated_reg;
  logic                   clk_level;
  logic                   kick;
  logic                   fit;

  function automatic logic [CNT_W-1:0] clamp(input logic [CNT_W-1:0] v,
                                             input int lo, input int hi);
    logic [CNT_W-1:0] r;
    r = v;
    if (v < CNT_W'(lo)) begin
      r = CNT_W'(lo);
    end else if (v > CNT_W'(hi)) begin
      r = CNT_W'(hi);
    end
    return r;
  endfunction

  assign width_eff = clamp(width_set, WIDTH_MIN_CYC, WIDTH_MAX_CYC);
  assign gap_eff   = clamp(gap_set, GAP_MIN_CYC, GAP_MAX_CYC);
  assign kick      = pin_rise[PIN_KICK];
  assign fit       = pin_level[PIN_SP_FIT];

  always_comb begin
    gen_next     = gen_reg;
    gen_cnt_next = gen_cnt_reg + 1'b1;
    if (fit) begin
      gen_next     = GEN_GAP;
      gen_cnt_next = '0;
    end else if (kick) begin
      // start kick forces a pulse phase
      gen_next     = GEN_PULSE;
      gen_cnt_next = '0;
    end else begin
      case (gen_reg)
        GEN_PULSE: begin
          if (gen_cnt_reg >= width_eff - 1'b1) begin
            gen_next     = GEN_GAP;
            gen_cnt_next = '0;
          end
        end
        GEN_GAP: begin
          if (gen_cnt_reg >= gap_eff - 1'b1) begin
            gen_next     = GEN_PULSE;
            gen_cnt_next = '0;
          end
        end
        default: begin
          gen_next     = GEN_PULSE;
          gen_cnt_next = '0;
        end
      endcase
    end
  end

  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      gen_reg     <= GEN_GAP;
      gen_cnt_reg <= '0;
    end else begin
      gen_reg     <= gen_next;
      gen_cnt_reg <= gen_cnt_next;
    end
  end

  assign clk_level = fit ? pin_level[PIN_SP_CLK] : (gen_reg == GEN_PULSE);

  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      clk_out_reg <= '0;
      gated_reg   <= 1'b0;
    end else begin
      clk_out_reg <= {NUM_CLK_OUT{clk_level}};
      gated_reg   <= clk_level && gated_clock_enable;
    end
  end

  assign clock_out       = clk_out_reg;
  assign gated_clock_out = gated_reg;

  // ----------------------------------------------------------------
  // checking helpers
  // ----------------------------------------------------------------
  logic [SPAN_W-1:0] since_cnt_reg;
  logic [SPAN_W-1:0] dsp_hi_reg;
  logic [CNT_W-1:0]  run_cnt_reg;
  logic              clk_prev_reg;
  logic              irr_reg;
  logic [CNT_W-1:0]  width_q_reg;
  logic [CNT_W-1:0]  gap_q_reg;
  logic              clk_edge;
  logic              set_chg;

  assign clk_edge = (clk_out_reg[0] != clk_prev_reg);
  // setting moved this cycle: the phase just ended used the old value
  assign set_chg  = (width_set != width_q_reg) || (gap_set != gap_q_reg);

  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      since_cnt_reg <= '0;
      dsp_hi_reg    <= '0;
      run_cnt_reg   <= '0;
      clk_prev_reg  <= 1'b0;
      irr_reg       <= 1'b1;
      width_q_reg   <= '0;
      gap_q_reg     <= '0;
    end else begin
      since_cnt_reg <= accept ? SPAN_W'(1) : since_cnt_reg + 1'b1;
      dsp_hi_reg    <= dsp_reg ? dsp_hi_reg + 1'b1 : '0;
      run_cnt_reg   <= clk_edge ? CNT_W'(1) : run_cnt_reg + 1'b1;
      clk_prev_reg  <= clk_out_reg[0];
      width_q_reg   <= width_set;
      gap_q_reg     <= gap_set;
      if (kick || fit || set_chg) begin
        irr_reg <= 1'b1;
      end else if (clk_edge) begin
        irr_reg <= 1'b0;
      end
    end
  end

  sequence seq_accept_start;
    pin_rise[PIN_START] && (seq_reg == SEQ_IDLE);
  endsequence

  sequence seq_enter_wait;
    (seq_reg == SEQ_WAIT) && rst_reg[0] ##0 rst_reg == '1;
  endsequence

  chk_start_fires: assert property (@(posedge sys_clk) disable iff (reset)
    seq_accept_start |=> seq_enter_wait)
    else $error("start trigger did not begin a sequence");

  chk_button_start: assert property (@(posedge sys_clk) disable iff (reset)
    (pin_rise[PIN_BUTTON] && (seq_reg == SEQ_IDLE)) |=> seq_enter_wait)
    else $error("button did not begin a sequence");

  chk_resets_done: assert property (@(posedge sys_clk) disable iff (reset)
    $rose(dsp_reg) |-> (rst_reg == '0))
    else $error("delayed pulse overlaps direct resets");

  chk_delay_len: assert property (@(posedge sys_clk) disable iff (reset)
    $rose(dsp_reg) |-> (since_cnt_reg == SPAN_W'(DELAY_CYC + 1)))
    else $error("delayed pulse started at wrong time");

  chk_pulse_len: assert property (@(posedge sys_clk) disable iff (reset)
    $fell(dsp_reg) |-> (dsp_hi_reg == SPAN_W'(PULSE_CYC)))
    else $error("delayed pulse has wrong width");

  chk_fire_cause: assert property (@(posedge sys_clk) disable iff (reset)
    $rose(dsp_reg) |-> ($past(seq_reg) == SEQ_WAIT) && (seq_reg == SEQ_FIRE))
    else $error("delayed pulse not fired by delay end");

  chk_reset_len: assert property (@(posedge sys_clk) disable iff (reset)
    $fell(rst_reg[0]) |-> (since_cnt_reg == SPAN_W'(RESET_CYC + 1)) && (rst_reg == '0))
    else $error("direct reset pulses have wrong width");

  chk_clk_width: assert property (@(posedge sys_clk) disable iff (reset)
    (clk_edge && !clk_out_reg[0] && !irr_reg && !set_chg) |-> (run_cnt_reg == width_eff))
    else $error("clock high phase has wrong length");

  chk_clk_gap: assert property (@(posedge sys_clk) disable iff (reset)
    (clk_edge && clk_out_reg[0] && !irr_reg && !set_chg) |-> (run_cnt_reg == gap_eff))
    else $error("clock gap has wrong length");

  chk_gated_follow: assert property (@(posedge sys_clk) disable iff (reset)
    gated_reg == (clk_out_reg[2] && $past(gated_clock_enable)))
    else $error("gated clock does not follow main clock and enable");

  chk_kick_starts: assert property (@(posedge sys_clk) disable iff (reset)
    (kick && !fit) |=> (gen_reg == GEN_PULSE) ##1 (clk_out_reg == '1))
    else $error("start kick did not force a clock pulse");

  chk_single_source: assert property (@(posedge sys_clk) disable iff (reset)
    fit |=> (clk_out_reg[1] == $past(pin_level[PIN_SP_CLK])) && (gen_reg == GEN_GAP))
    else $error("fitted single-pulse unit not driving clocks");

endmodule

// File: rtl/sts_pkg.sv
// Purpose: shared constants and types for the start and clock timing block
// Assumes: sys_clk at 100 MHz
// Notes:   all times are kept in their own unit; the nanosecond times are turned into cycle counts here
package sts_pkg;

  // ----------------------------------------------------------------
  // clock rate
  // ----------------------------------------------------------------
  localparam int CLK_MHZ     = 100;
  localparam int NS_PER_US   = 1000;
  localparam int TICK_CYCLES = CLK_MHZ;

  // ----------------------------------------------------------------
  // start sequence times, microseconds
  // ----------------------------------------------------------------
  localparam int DELAY_US_MIN = 67;
  localparam int DELAY_US_MAX = 97;
  localparam int DELAY_US_NOM = 80;
  localparam int PULSE_US_MIN = 12;
  localparam int PULSE_US_MAX = 20;
  localparam int PULSE_US_NOM = 16;
  localparam int RESET_US_MIN = 37;
  localparam int RESET_US_MAX = 64;
  localparam int RESET_US_NOM = 50;

  // ----------------------------------------------------------------
  // clock generator and glitch filter times, nanoseconds
  // ----------------------------------------------------------------
  localparam int CLK_HIGH_NS  = 1000;
  localparam int CLK_GAP_NS   = 11000;
  localparam int WIDTH_MIN_NS = 750;
  localparam int WIDTH_MAX_NS = 1400;
  localparam int GAP_MIN_NS   = 8000;
  localparam int GAP_MAX_NS   = 27000;
  localparam int GLITCH_NS    = 40;

  localparam int CLK_HIGH_CYC  = CLK_HIGH_NS * CLK_MHZ / NS_PER_US;
  localparam int CLK_GAP_CYC   = CLK_GAP_NS * CLK_MHZ / NS_PER_US;
  localparam int WIDTH_MIN_CYC = (WIDTH_MIN_NS * CLK_MHZ + NS_PER_US - 1) / NS_PER_US;
  localparam int WIDTH_MAX_CYC = WIDTH_MAX_NS * CLK_MHZ / NS_PER_US;
  localparam int GAP_MIN_CYC   = (GAP_MIN_NS * CLK_MHZ + NS_PER_US - 1) / NS_PER_US;
  localparam int GAP_MAX_CYC   = GAP_MAX_NS * CLK_MHZ / NS_PER_US;
  localparam int GLITCH_CYC    = (GLITCH_NS * CLK_MHZ + NS_PER_US - 1) / NS_PER_US;

  // ----------------------------------------------------------------
  // widths and pin slots
  // ----------------------------------------------------------------
  localparam int CNT_W       = 12;
  localparam int US_W        = 8;
  localparam int SPAN_W      = 16;
  localparam int NUM_CLK_OUT = 3;
  localparam int NUM_RESET   = 3;
  localparam int NUM_PINS    = 5;
  localparam int PIN_START   = 0;
  localparam int PIN_BUTTON  = 1;
  localparam int PIN_KICK    = 2;
  localparam int PIN_SP_CLK  = 3;
  localparam int PIN_SP_FIT  = 4;

  // ----------------------------------------------------------------
  // state types
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    SEQ_IDLE = 3'h1,
    SEQ_WAIT = 3'h2,
    SEQ_FIRE = 3'h4
  } sts_seq_t;

  typedef enum logic [1:0] {
    GEN_PULSE = 2'h1,
    GEN_GAP   = 2'h2
  } sts_gen_t;

endpackage

// File: rtl/sts_pin_if.sv
// Purpose: carries one filtered pin from its filter to the sequencer or the clock generator
// Assumes: single clock domain
// Notes:   level and rise both come from flip-flops
`timescale 1ns/1ns
interface sts_pin_if;
  logic level;
  logic rise;
  modport src (output level, output rise);
  modport dst (input level, input rise);
endinterface

// File: rtl/sts_pin_filter.sv
// Purpose: two-stage synchroniser plus glitch filter for one pin
// Assumes: pin is asynchronous to sys_clk
// Notes:   level follows only after FILT_CYC stable cycles
`timescale 1ns/1ns
module sts_pin_filter
  import sts_pkg::*;
#(
  parameter int FILT_CYC = GLITCH_CYC
) (
  // clock and reset
  input  wire logic sys_clk,
  input  wire logic reset,
  // raw pin
  input  wire logic pin_raw,
  // filtered result
  sts_pin_if.src    link
);

  localparam int FW = $clog2(FILT_CYC + 1);

  logic          s1_reg;
  logic          s2_reg;
  logic [FW-1:0] stable_cnt_reg;
  logic          level_reg;
  logic          rise_reg;
  logic          accept;

  // ----------------------------------------------------------------
  // synchroniser
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      s1_reg <= 1'b0;
      s2_reg <= 1'b0;
    end else begin
      s1_reg <= pin_raw;
      s2_reg <= s1_reg;
    end
  end

  // ----------------------------------------------------------------
  // glitch filter
  // ----------------------------------------------------------------
  assign accept = (s2_reg != level_reg) && (stable_cnt_reg == FW'(FILT_CYC - 1));

  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      stable_cnt_reg <= '0;
      level_reg      <= 1'b0;
    end else if (s2_reg == level_reg) begin
      stable_cnt_reg <= '0;
    end else if (accept) begin
      stable_cnt_reg <= '0;
      level_reg      <= s2_reg;
    end else begin
      stable_cnt_reg <= stable_cnt_reg + 1'b1;
    end
  end

  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      rise_reg <= 1'b0;
    end else begin
      rise_reg <= accept && s2_reg;
    end
  end

  assign link.level = level_reg;
  assign link.rise  = rise_reg;

  chk_glitch_ignore: assert property (@(posedge sys_clk) disable iff (reset)
    $rose(level_reg) |-> ($past(s2_reg, 1) && $past(s2_reg, 2) && $past(s2_reg, 3)
                          && $past(s2_reg, 4)))
    else $error("filtered level rose without four stable samples");

  chk_rise_edge: assert property (@(posedge sys_clk) disable iff (reset)
    rise_reg |-> (level_reg && !$past(level_reg)))
    else $error("rise pulse without a rising filtered level");

endmodule

// File: dv/sts_logic_model.sv
// Purpose: far-side machine logic that presets its flops from the start pulse
// Assumes: block outputs sampled on sys_clk
// Notes:   behavioural; direct reset clears, delayed start loads the selection
`timescale 1ns/1ns
module sts_logic_model
  import sts_pkg::*;
(
  // clock and reset
  input  wire logic       sys_clk,
  input  wire logic       reset,
  // block outputs
  input  wire logic       clear_pulse,
  input  wire logic       start_pulse,
  // panel selection
  input  wire logic [3:0] prog_select,
  // preset result
  output logic      [3:0] held_reg
);
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      held_reg <= 4'h0;
    end else if (clear_pulse) begin
      held_reg <= 4'h0;
    end else if (start_pulse) begin
      held_reg <= prog_select;
    end
  end
endmodule

// File: dv/sts_start_clock_tb_top.sv
// Purpose: self-checking bench for the start and clock timing block
// Assumes: microsecond tick shortened to TCK cycles
// Notes:   inputs change 1 ns after the rising edge
`timescale 1ns/1ns
module sts_start_clock_tb_top;
  import sts_pkg::*;
  localparam int TCK   = 4;
  localparam int LIMIT = 90000;
  // ----------------------------------------------------------------
  // signals
  // ----------------------------------------------------------------
  logic                   sys_clk, reset, start_trigger, manual_start_button;
  logic                   clock_start, single_pulse_clock, single_pulse_fitted;
  logic [CNT_W-1:0]       width_set, gap_set;
  logic                   gated_clock_enable, gated_clock_out, delayed_start_pulse;
  logic [NUM_CLK_OUT-1:0] clock_out;
  logic                   direct_reset_pulse_one, direct_reset_pulse_two;
  logic                   direct_reset_pulse_three, same;
  logic [3:0]             prog_sel, held;
  int                     bad_count, total_checks, cycles;
  int ws[4] = '{CLK_HIGH_CYC, WIDTH_MIN_CYC, WIDTH_MAX_CYC, 12'h00A};
  int gs[4] = '{CLK_GAP_CYC, GAP_MIN_CYC, GAP_MAX_CYC, 12'hFFF};
  int we[4] = '{CLK_HIGH_CYC, WIDTH_MIN_CYC, WIDTH_MAX_CYC, WIDTH_MIN_CYC};
  int ge[4] = '{CLK_GAP_CYC, GAP_MIN_CYC, GAP_MAX_CYC, GAP_MAX_CYC};

  sts_start_clock_top #(.TICK_CYC(TCK)) uut (
    .sys_clk(sys_clk), .reset(reset), .start_trigger(start_trigger),
    .manual_start_button(manual_start_button), .clock_start(clock_start),
    .single_pulse_clock(single_pulse_clock), .single_pulse_fitted(single_pulse_fitted),
    .width_set(width_set), .gap_set(gap_set), .gated_clock_enable(gated_clock_enable),
    .clock_out(clock_out), .gated_clock_out(gated_clock_out),
    .direct_reset_pulse_one(direct_reset_pulse_one),
    .direct_reset_pulse_two(direct_reset_pulse_two),
    .direct_reset_pulse_three(direct_reset_pulse_three),
    .delayed_start_pulse(delayed_start_pulse));

  sts_logic_model model (.sys_clk(sys_clk), .reset(reset),
    .clear_pulse(direct_reset_pulse_one), .start_pulse(delayed_start_pulse),
    .prog_select(prog_sel), .held_reg(held));

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end

  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == LIMIT) begin
      bad_count++;
      results();
    end
  end

  task automatic step(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("wrong value at %0t: got %0h expected %0h", $time, got, exp);
    end
  endtask

  task automatic results();
    $display("checks %0d mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  // aligns to a fresh rise, then counts high and low cycles
  task automatic meas_clk(output int hi, output int lo);
    int n;
    n = 0;
    while (clock_out[0] !== 1'b0 && n < 3000) begin
      step(1);
      n++;
    end
    while (clock_out[0] !== 1'b1 && n < 6000) begin
      step(1);
      n++;
    end
    hi = 0;
    lo = 0;
    while (clock_out[0] === 1'b1 && hi < 3000) begin
      same &= (clock_out === {NUM_CLK_OUT{1'b1}});
      step(1);
      hi++;
    end
    while (clock_out[0] === 1'b0 && lo < 3000) begin
      same &= (clock_out === {NUM_CLK_OUT{1'b0}});
      step(1);
      lo++;
    end
  endtask

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic test_clock();
    int hi, lo;
    same = 1'b1;
    for (int i = 0; i < 4; i++) begin
      width_set = CNT_W'(ws[i]);
      gap_set = CNT_W'(gs[i]);
      meas_clk(hi, lo);
      meas_clk(hi, lo);
      check(hi, we[i]);
      check(lo, ge[i]);
    end
    check(same, 1'b1);
    width_set = CNT_W'(CLK_HIGH_CYC);
    gap_set = CNT_W'(CLK_GAP_CYC);
    meas_clk(hi, lo);
    meas_clk(hi, lo);
    check(hi + lo, CLK_HIGH_CYC + CLK_GAP_CYC);
    $display("test clock done");
  endtask

  task automatic test_gate();
    logic err;
    err = 1'b0;
    for (int e = 0; e < 2; e++) begin
      gated_clock_enable = e[0];
      step(2);
      repeat (1300) begin
        err |= (gated_clock_out !== (clock_out[0] & gated_clock_enable));
        step(1);
      end
    end
    gated_clock_enable = 1'b0;
    check(err, 1'b0);
    $display("test gate done");
  endtask

  task automatic test_kick();
    int n;
    n = 0;
    // kick early in a fresh gap, far before the natural rise
    while (clock_out[0] !== 1'b1 && n < 3000) begin
      step(1);
      n++;
    end
    while (clock_out[0] !== 1'b0 && n < 6000) begin
      step(1);
      n++;
    end
    step(200);
    clock_start = 1'b1;
    n = 0;
    while (clock_out[0] !== 1'b1 && n < 30) begin
      step(1);
      n++;
    end
    clock_start = 1'b0;
    check(n < 15, 1'b1);
    step(20);
    $display("test kick done");
  endtask

  task automatic run_seq(input bit use_btn, input logic [3:0] sel);
    int n, r, d, p;
    logic bad3, diff, again;
    bad3 = 1'b0;
    diff = 1'b0;
    again = 1'b0;
    n = 0;
    r = 0;
    d = 0;
    p = 0;
    prog_sel = sel;
    {start_trigger, manual_start_button} = {!use_btn, use_btn};
    while (direct_reset_pulse_one !== 1'b1 && n < 40) begin
      step(1);
      n++;
    end
    while (direct_reset_pulse_one === 1'b1 && r < 1000) begin
      bad3 |= (delayed_start_pulse !== 1'b0);
      diff |= (direct_reset_pulse_two !== 1'b1) | (direct_reset_pulse_three !== 1'b1);
      if (r == 10) {start_trigger, manual_start_button} = 2'b00;
      if (r == 30) {start_trigger, manual_start_button} = {!use_btn, use_btn};
      step(1);
      r++;
    end
    while (delayed_start_pulse !== 1'b1 && d < 2000) begin
      step(1);
      d++;
    end
    while (delayed_start_pulse === 1'b1 && p < 1000) begin
      step(1);
      p++;
    end
    repeat (300) begin
      again |= (direct_reset_pulse_one !== 1'b0) | (delayed_start_pulse !== 1'b0);
      step(1);
    end
    check(n < 40, 1'b1);
    check(r, RESET_US_NOM * TCK);
    check(diff, 1'b0);
    check(bad3, 1'b0);
    check(r + d, DELAY_US_NOM * TCK);
    check(p, PULSE_US_NOM * TCK);
    check(again, 1'b0);
    check(held, sel);
    {start_trigger, manual_start_button} = 2'b00;
    step(20);
    $display("test start sequence done");
  endtask

  task automatic test_glitch();
    logic seen;
    seen = 1'b0;
    start_trigger = 1'b1;
    step(3);
    start_trigger = 1'b0;
    repeat (500) begin
      seen |= (direct_reset_pulse_one !== 1'b0) | (delayed_start_pulse !== 1'b0);
      step(1);
    end
    check(seen, 1'b0);
    $display("test glitch done");
  endtask

  task automatic test_fit();
    logic err;
    int n;
    err = 1'b0;
    single_pulse_fitted = 1'b1;
    step(20);
    repeat (3000) begin
      err |= (clock_out[0] !== 1'b0);
      step(1);
    end
    check(err, 1'b0);
    single_pulse_clock = 1'b1;
    n = 0;
    while (clock_out[0] !== 1'b1 && n < 20) begin
      step(1);
      n++;
    end
    check(n < 12, 1'b1);
    single_pulse_clock = 1'b0;
    n = 0;
    while (clock_out[0] !== 1'b0 && n < 20) begin
      step(1);
      n++;
    end
    check(n < 12, 1'b1);
    single_pulse_fitted = 1'b0;
    $display("test single pulse done");
  endtask

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    {start_trigger, manual_start_button, clock_start} = 3'h0;
    reset = 1'b1;
    {single_pulse_clock, single_pulse_fitted, gated_clock_enable} = 3'h0;
    width_set = CNT_W'(CLK_HIGH_CYC);
    gap_set = CNT_W'(CLK_GAP_CYC);
    prog_sel = 4'h0;
    {bad_count, total_checks, cycles} = {32'h0, 32'h0, 32'h0};
    repeat (12) @(posedge sys_clk);
    #1;
    reset = 1'b0;
    step(5);
    test_clock();
    test_gate();
    test_kick();
    run_seq(1'b0, 4'hA);
    run_seq(1'b1, 4'h5);
    test_glitch();
    test_fit();
    results();
  end
endmodule
